// file: io_pin_routing.sv
/*
 Pin routing and input select block: analog/digital selection, port reads,
 fixed-priority function ownership, pulls, high core-voltage tri-state and
 three remappable peripheral input selectors, all behind an APB slave.
 Assumes pad inputs, the voltage detect and remappable sources are asynchronous.
*/
// The register offsets and the APB slave port were left to the implementer.
// Behaviour
// - After reset every analog-capable pin is analog with digital input off.
// - Analog pins disable input buffer; port and latch reads return zero.
// - Writing zero to an analog-select bit makes the pin digital.
// - Output driver still works when direction is output while analog.
// - Highest-priority enabled function owns a shared pin; others have no effect.
// - Each pin has independently enabled weak pull-up and pull-down.
// - High core-voltage detect tri-states all pins while it stays asserted.
// - Timer-2 clock selector is bits 7-0; upper byte reads zero.
// - Codes decode b5 to pin 181, 01 to comparator, 00 to ground.
module io_pin_routing
    import pin_route_pkg::*;
(
    input  wire logic                  ref_clk,      // System clock, 250 MHz
    input  wire logic                  rst_n,        // Async reset, active low
    input  wire logic                  psel,         // APB select
    input  wire logic                  penable,      // APB enable
    input  wire logic                  pwrite,       // APB direction
    input  wire logic [ADDR_W-1:0]     paddr,        // APB byte address
    input  wire logic [31:0]           pwdata,       // APB write data
    output logic      [31:0]           prdata,       // APB read data
    output logic                       pready,       // APB ready
    output logic                       pslverr,      // APB error
    input  wire logic [NUM_PINS-1:0]   pad_in,       // Pad input levels
    output logic      [NUM_PINS-1:0]   pad_out,      // Pad drive levels
    output logic      [NUM_PINS-1:0]   pad_oe,       // Pad output enables
    output logic      [NUM_PINS-1:0]   pad_pull_up,  // Weak pull-up enables
    output logic      [NUM_PINS-1:0]   pad_pull_dn,  // Weak pull-down enables
    output logic      [NUM_PINS-1:0]   pad_in_en,    // Digital input buffer enables
    input  wire pin_func_s [NUM_PINS-1:0] func_req,  // Peripheral requests per pin
    input  wire logic                  high_core_voltage_detect, // Async detect
    input  wire logic                  comparator_one_output,    // Async comparator
    input  wire logic [RP_COUNT-1:0]   rp_src,       // Remappable pins, code 2 up
    output logic                       timer2_external_clock, // Routed input
    output logic                       nibble_link1_input,    // Routed input
    output logic                       nibble_link2_input     // Routed input
);
    logic [NUM_PINS-1:0] analog_select_bits;
    logic [NUM_PINS-1:0] direction_register;
    logic [NUM_PINS-1:0] output_latch_register;
    logic [NUM_PINS-1:0] pullup_enable_bits;
    logic [NUM_PINS-1:0] pulldown_enable_bits;
    sel_set_s            sel;

    logic [NUM_PINS-1:0] pad_s1, pad_s2, pad_s3, pad_level;
    logic [2:0]          hv_sync;
    logic                hv_level;
    logic [2:0]          cmp_sync;
    logic                cmp_level;
    logic [RP_COUNT-1:0] rp_s1, rp_s2, rp_s3, rp_level;
    pad_ctrl_s [NUM_PINS-1:0] next_pad;

    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // Address decode, used by the write enable and the pslverr response
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_ANALOG_SEL, ADDR_DIRECTION, ADDR_OUT_LATCH, ADDR_PIN_LEVEL,
            ADDR_PULLUP, ADDR_PULLDOWN, ADDR_T2_SEL, ADDR_NL1_SEL,
            ADDR_NL2_SEL, ADDR_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // Digital read value: analog pins always read zero
    function automatic logic [NUM_PINS-1:0] digital_view(
        input logic [NUM_PINS-1:0] v,
        input logic [NUM_PINS-1:0] ana);
        digital_view = v & ~(ana & ANALOG_CAPABLE);
    endfunction

    assign addr_ok = mapped(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite;
    // Zero-wait slave; unmapped addresses answer with pslverr
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Pad input synchronisers; a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1    <= ZERO_PINS;
            pad_s2    <= ZERO_PINS;
            pad_s3    <= ZERO_PINS;
            pad_level <= ZERO_PINS;
        end else begin
            pad_s1    <= pad_in;
            pad_s2    <= pad_s1;
            pad_s3    <= pad_s2;
            for (int i = 0; i < NUM_PINS; i++) begin
                if (pad_s2[i] == pad_s3[i]) begin
                    pad_level[i] <= pad_s3[i];
                end
            end
        end
    end

    // Remappable source synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_s1    <= '0;
            rp_s2    <= '0;
            rp_s3    <= '0;
            rp_level <= '0;
        end else begin
            rp_s1    <= rp_src;
            rp_s2    <= rp_s1;
            rp_s3    <= rp_s2;
            rp_level <= (rp_s2 & rp_s3) | (rp_level & (rp_s2 | rp_s3));
        end
    end

    // Voltage detect and comparator synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hv_sync   <= 3'h0;
            hv_level  <= 1'b0;
            cmp_sync  <= 3'h0;
            cmp_level <= 1'b0;
        end else begin
            hv_sync  <= {hv_sync[1:0], high_core_voltage_detect};
            cmp_sync <= {cmp_sync[1:0], comparator_one_output};
            if (hv_sync[1] == hv_sync[2]) begin
                hv_level <= hv_sync[2];
            end
            if (cmp_sync[1] == cmp_sync[2]) begin
                cmp_level <= cmp_sync[2];
            end
        end
    end

    // Port configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_select_bits    <= ANALOG_SEL_RST & ANALOG_CAPABLE;
            direction_register    <= DIRECTION_RST;
            output_latch_register <= ZERO_PINS;
        end else if (wr_en) begin
            case (paddr)
                ADDR_ANALOG_SEL: analog_select_bits <= pwdata[NUM_PINS-1:0]
                                                       & ANALOG_CAPABLE;
                ADDR_DIRECTION:  direction_register    <= pwdata[NUM_PINS-1:0];
                ADDR_OUT_LATCH:  output_latch_register <= pwdata[NUM_PINS-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_enable_bits   <= ZERO_PINS;
            pulldown_enable_bits <= ZERO_PINS;
        end else if (wr_en) begin
            case (paddr)
                ADDR_PULLUP:   pullup_enable_bits   <= pwdata[NUM_PINS-1:0];
                ADDR_PULLDOWN: pulldown_enable_bits <= pwdata[NUM_PINS-1:0];
                default: ;
            endcase
        end
    end

    // Input selector fields
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel.t2  <= SEL_RST;
            sel.nl1 <= SEL_RST;
            sel.nl2 <= SEL_RST;
        end else if (wr_en) begin
            case (paddr)
                ADDR_T2_SEL:  sel.t2  <= pwdata[T2_SEL_LSB +: SEL_W];
                ADDR_NL1_SEL: sel.nl1 <= pwdata[NL1_SEL_LSB +: SEL_W];
                ADDR_NL2_SEL: sel.nl2 <= pwdata[NL2_SEL_LSB +: SEL_W];
                default: ;
            endcase
        end
    end

    // Read data register; unimplemented bits read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                ADDR_ANALOG_SEL: prdata[NUM_PINS-1:0] <= analog_select_bits;
                ADDR_DIRECTION:  prdata[NUM_PINS-1:0] <= direction_register;
                ADDR_OUT_LATCH:  prdata[NUM_PINS-1:0] <=
                    digital_view(output_latch_register, analog_select_bits);
                ADDR_PIN_LEVEL:  prdata[NUM_PINS-1:0] <=
                    digital_view(pad_level, analog_select_bits);
                ADDR_PULLUP:     prdata[NUM_PINS-1:0] <= pullup_enable_bits;
                ADDR_PULLDOWN:   prdata[NUM_PINS-1:0] <= pulldown_enable_bits;
                ADDR_T2_SEL:     prdata[T2_SEL_LSB +: SEL_W]  <= sel.t2;
                ADDR_NL1_SEL:    prdata[NL1_SEL_LSB +: SEL_W] <= sel.nl1;
                ADDR_NL2_SEL:    prdata[NL2_SEL_LSB +: SEL_W] <= sel.nl2;
                ADDR_STATUS:     prdata[0] <= hv_level;
                default: ;
            endcase
        end
    end

    // Pad control: a function owns the pin from the first enabled index;
    // port logic only drives when no peripheral function is enabled
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            next_pad[p].drive     = output_latch_register[p];
            next_pad[p].oe        = !direction_register[p];
            for (int f = NUM_FUNCS - 1; f >= 0; f--) begin
                if (func_req[p].en[f]) begin
                    next_pad[p].drive = func_req[p].drive[f];
                    next_pad[p].oe    = func_req[p].oe[f];
                end
            end
            next_pad[p].pull_up   = pullup_enable_bits[p];
            next_pad[p].pull_down = pulldown_enable_bits[p];
            next_pad[p].in_buf_en = !(analog_select_bits[p] && ANALOG_CAPABLE[p]);
            if (hv_level) begin
                next_pad[p].oe        = 1'b0;
                next_pad[p].pull_up   = 1'b0;
                next_pad[p].pull_down = 1'b0;
                next_pad[p].in_buf_en = 1'b0;
            end
        end
    end

    // Registered pad controls; the detect clears enables only through the filtered hv_level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out     <= ZERO_PINS;
            pad_oe      <= ZERO_PINS;
            pad_pull_up <= ZERO_PINS;
            pad_pull_dn <= ZERO_PINS;
            pad_in_en   <= ZERO_PINS;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                pad_out[p]     <= next_pad[p].drive;
                pad_oe[p]      <= next_pad[p].oe;
                pad_pull_up[p] <= next_pad[p].pull_up;
                pad_pull_dn[p] <= next_pad[p].pull_down;
                pad_in_en[p]   <= next_pad[p].in_buf_en;
            end
        end
    end

    input_source_mux u_t2_mux (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .code    (sel.t2),
        .cmp_in  (cmp_level),
        .rp_in   (rp_level),
        .sel_out (timer2_external_clock)
    );

    input_source_mux u_nl1_mux (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .code    (sel.nl1),
        .cmp_in  (cmp_level),
        .rp_in   (rp_level),
        .sel_out (nibble_link1_input)
    );

    input_source_mux u_nl2_mux (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .code    (sel.nl2),
        .cmp_in  (cmp_level),
        .rp_in   (rp_level),
        .sel_out (nibble_link2_input)
    );
endmodule // io_pin_routing

// file: pin_route_pkg.sv
/*
 Package for the pin routing block: register map, field layout, reset values,
 carrier structs and pin count. Assumes a 32-bit APB slave on the system clock.
*/
package pin_route_pkg;
    localparam int unsigned NUM_PINS   = 16;
    localparam int unsigned SEL_W      = 8;
    localparam int unsigned NUM_FUNCS  = 4;
    localparam int unsigned ADDR_W     = 8;

    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] ADDR_ANALOG_SEL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DIRECTION   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_OUT_LATCH   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL   = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PULLUP      = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_PULLDOWN    = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_T2_SEL      = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_NL1_SEL     = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_NL2_SEL     = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h24;

    // Field positions of the selector fields within their registers
    localparam int unsigned T2_SEL_LSB  = 0;
    localparam int unsigned NL1_SEL_LSB = 8;
    localparam int unsigned NL2_SEL_LSB = 0;

    // Reset values
    localparam logic [NUM_PINS-1:0] ANALOG_SEL_RST = 16'hffff;
    localparam logic [NUM_PINS-1:0] DIRECTION_RST  = 16'hffff;
    localparam logic [NUM_PINS-1:0] ZERO_PINS      = 16'h0000;
    localparam logic [SEL_W-1:0]    SEL_RST        = 8'h00;

    // Selector codes
    localparam logic [SEL_W-1:0] SEL_GROUND     = 8'h00;
    localparam logic [SEL_W-1:0] SEL_COMPARATOR = 8'h01;
    localparam logic [SEL_W-1:0] SEL_RP_181     = 8'hb5;
    localparam int unsigned      RP_BASE        = 2;
    localparam int unsigned      RP_COUNT       = 180;

    // Which pins carry an analog input function (one bit per pin)
    localparam logic [NUM_PINS-1:0] ANALOG_CAPABLE = 16'h0fff;

    // Per-pin shared functions in fixed priority order, index 0 highest
    typedef struct packed {
        logic [NUM_FUNCS-1:0] en;
        logic [NUM_FUNCS-1:0] drive;
        logic [NUM_FUNCS-1:0] oe;
    } pin_func_s;

    typedef struct packed {
        logic drive;
        logic oe;
        logic pull_up;
        logic pull_down;
        logic in_buf_en;
    } pad_ctrl_s;

    typedef struct packed {
        logic [SEL_W-1:0] t2;
        logic [SEL_W-1:0] nl1;
        logic [SEL_W-1:0] nl2;
    } sel_set_s;
endpackage

// file: input_source_mux.sv
/*
 One remappable input selector: decodes an 8-bit code to ground, comparator
 output or one remappable pin. Sources are already synchronised to ref_clk.
*/
module input_source_mux
    import pin_route_pkg::*;
(
    input  wire logic                ref_clk,   // System clock
    input  wire logic                rst_n,     // Async reset, active low
    input  wire logic [SEL_W-1:0]    code,      // Selector field
    input  wire logic                cmp_in,    // Comparator one output
    input  wire logic [RP_COUNT-1:0] rp_in,     // Remappable pins from code 2 up
    output logic                     sel_out    // Routed peripheral input
);
    logic next_sel;

    always_comb begin
        if (code == SEL_GROUND) begin
            next_sel = 1'b0;
        end else if (code == SEL_COMPARATOR) begin
            next_sel = cmp_in;
        end else if (code <= SEL_RP_181) begin
            next_sel = rp_in[code - SEL_W'(RP_BASE)];
        end else begin
            next_sel = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_out <= 1'b0;
        end else begin
            sel_out <= next_sel;
        end
    end
endmodule // input_source_mux

// file: pin_route_properties.sv
/*
 Checker bound to io_pin_routing: reset state, register fields, pad control.
 Assumes the pin_route_pkg map and one-edge pad update after a register write.
*/
module pin_route_properties
    import pin_route_pkg::*;
(
    input wire logic                ref_clk,                  // Clock
    input wire logic                rst_n,                    // Reset, low
    input wire logic                psel,                     // APB select
    input wire logic                penable,                  // APB enable
    input wire logic                pwrite,                   // APB write
    input wire logic [ADDR_W-1:0]   paddr,                    // APB address
    input wire logic [31:0]         pwdata,                   // Write data
    input wire logic [31:0]         prdata,                   // Read data
    input wire logic [NUM_PINS-1:0] pad_oe,                   // Output enables
    input wire logic [NUM_PINS-1:0] pad_pull_up,              // Pull-ups
    input wire logic [NUM_PINS-1:0] pad_in_en,                // Input buffers
    input wire logic                high_core_voltage_detect, // Detect
    input wire logic                timer2_external_clock     // Routed input
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;
    wire logic hv = high_core_voltage_detect;

    a_reset_analog: assert property ($rose(rst_n) |-> ##1 pad_in_en == ~ANALOG_CAPABLE)
        else $error("analog pins not analog after reset");
    a_analog_write: assert property (wr && paddr == ADDR_ANALOG_SEL && !hv |->
        ##2 (pad_in_en & ANALOG_CAPABLE) == (~$past(pwdata[15:0], 2) & ANALOG_CAPABLE))
        else $error("input buffers do not follow analog select");
    a_pullup_write: assert property (wr && paddr == ADDR_PULLUP && !hv ##1 !hv
        |=> pad_pull_up == $past(pwdata[15:0], 2))
        else $error("pull-ups do not follow their register");
    a_hv_tristate: assert property (hv [*7] |-> !(|{pad_oe, pad_pull_up, pad_in_en}))
        else $error("pads active during high core voltage");
    a_t2_upper: assert property (rd && paddr == ADDR_T2_SEL |-> prdata[31:8] == 24'h000000)
        else $error("timer selector upper bits not zero");
    a_link1_bytes: assert property (rd && paddr == ADDR_NL1_SEL |->
        prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00)
        else $error("link one selector spare bits not zero");
    a_link2_upper: assert property (rd && paddr == ADDR_NL2_SEL |-> prdata[31:8] == 24'h0)
        else $error("link two selector upper bits not zero");
    a_route_ground: assert property ($rose(rst_n) |-> !timer2_external_clock [*3])
        else $error("routed input not ground after reset");
endmodule // pin_route_properties

bind io_pin_routing pin_route_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_in_en(pad_in_en),
    .high_core_voltage_detect(high_core_voltage_detect),
    .timer2_external_clock(timer2_external_clock)
);

// file: pin_board_model.sv
/*
 Board side of the pads: block drive wins, then a bench driver, then pulls.
 Assumes the bench changes ext_en and ext_lvl just after rising edges.
*/
module pin_board_model
    import pin_route_pkg::*;
(
    input  wire logic                ref_clk,     // Clock
    input  wire logic                rst_n,       // Reset, low
    input  wire logic [NUM_PINS-1:0] pad_out,     // Block levels
    input  wire logic [NUM_PINS-1:0] pad_oe,      // Block enables
    input  wire logic [NUM_PINS-1:0] pad_pull_up, // Pull-ups
    input  wire logic [NUM_PINS-1:0] pad_pull_dn, // Pull-downs
    input  wire logic [NUM_PINS-1:0] ext_en,      // Board driver on
    input  wire logic [NUM_PINS-1:0] ext_lvl,     // Board levels
    output logic      [NUM_PINS-1:0] pad_in       // Pad levels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_PINS-1:0] float_lvl;
    // A pad nobody holds toggles every edge, so the input filter holds its last stable level for a read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            float_lvl <= 16'h5a5a;
        end else begin
            float_lvl <= ~float_lvl;
        end
    end
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl)
        | (~pad_oe & ~ext_en & (pad_pull_up | (~pad_pull_dn & float_lvl)));
endmodule // pin_board_model

// file: io_pin_routing_tb.sv
/*
 Self-checking bench for io_pin_routing: APB master task, a task per scenario.
 Assumes a 250 MHz ref_clk and the board model on the pads.
*/
module io_pin_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_route_pkg::*;
    logic                     ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, re;
    logic [ADDR_W-1:0]        paddr;
    logic [31:0]              pwdata, prdata, rq;
    logic [NUM_PINS-1:0]      pad_in, pad_out, pad_oe, pull_up, pull_dn, in_en, ext_en, ext_lvl;
    pin_func_s [NUM_PINS-1:0] func_req;
    logic                     hv, cmp, t2_clk, nl1_in, nl2_in;
    logic [RP_COUNT-1:0]      rp_src;
    int                       err_total, samples_checked;

    io_pin_routing uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pull_up), .pad_pull_dn(pull_dn), .pad_in_en(in_en), .func_req(func_req),
        .high_core_voltage_detect(hv), .comparator_one_output(cmp), .rp_src(rp_src),
        .timer2_external_clock(t2_clk), .nibble_link1_input(nl1_in),
        .nibble_link2_input(nl2_in));
    pin_board_model u_board (.ref_clk(ref_clk), .rst_n(rst_n), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pull_up(pull_up), .pad_pull_dn(pull_dn), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pad_in(pad_in));

    always #2 ref_clk = ~ref_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Called just after a rising edge; ends after one idle edge so psel never toggles twice
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            check("pready", 32'h1, {31'h0, pready});
            end_sim();
        end else begin
            rq = prdata;
            re = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge ref_clk);
        end
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check($sformatf("reg %h", a), exp, rq);
    endtask

    task automatic t_reset();
        check("in_en", {16'h0, ~ANALOG_CAPABLE}, {16'h0, in_en});
        check("routed", 32'h0, {29'h0, t2_clk, nl1_in, nl2_in});
        rd_chk(ADDR_ANALOG_SEL, {16'h0, ANALOG_CAPABLE});
        rd_chk(ADDR_NL1_SEL, 32'h0);
        apb(1'h0, 8'h28, 32'h0);
        check("unmapped", 32'h1, {rq[30:0], re});
    endtask
    task automatic t_analog();
        ext_en <= 16'hffff;
        ext_lvl <= 16'hffff;
        tick(8);
        rd_chk(ADDR_PIN_LEVEL, {16'h0, ~ANALOG_CAPABLE});
        apb(1'h1, ADDR_ANALOG_SEL, 32'h00000ff0);
        tick(8);
        rd_chk(ADDR_PIN_LEVEL, 32'h0000f00f);
        check("in_en", 32'h0000f00f, {16'h0, in_en});
        apb(1'h1, ADDR_OUT_LATCH, 32'h0000ffff);
        rd_chk(ADDR_OUT_LATCH, 32'h0000f00f);
    endtask
    task automatic t_drive();
        ext_en <= 16'h0000;
        apb(1'h1, ADDR_ANALOG_SEL, 32'h00000fff);
        apb(1'h1, ADDR_OUT_LATCH, 32'h000000a5);
        apb(1'h1, ADDR_DIRECTION, 32'h00000000);
        tick(1);
        check("drive", 32'hffff00a5, {pad_oe, pad_out});
        apb(1'h1, ADDR_DIRECTION, 32'h0000ffff);
    endtask
    task automatic t_priority();
        logic [11:0] cases [4] = '{12'hf11, 12'he26, 12'h664, 12'h404};
        int k;
        foreach (cases[j]) begin
            func_req[5] <= cases[j];
            tick(2);
            k = 0;
            while (!cases[j][8+k]) k++;
            check("fn_out", {31'h0, cases[j][4+k]}, {31'h0, pad_out[5]});
            check("fn_oe", {31'h0, cases[j][k]}, {31'h0, pad_oe[5]});
        end
        func_req[5] <= 12'h000;
    endtask
    task automatic t_pulls();
        apb(1'h1, ADDR_PULLUP, 32'h000000ff);
        apb(1'h1, ADDR_PULLDOWN, 32'h0000f0f0);
        tick(1);
        check("pulls", 32'h00fff0f0, {pull_up, pull_dn});
    endtask
    task automatic t_select();
        logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hb5, 8'h02};
        logic e;
        for (int p = 0; p < 2; p++) begin
            cmp <= ~p[0];
            rp_src <= {~p[0], {(RP_COUNT - 1){p[0]}}};
            foreach (codes[j]) begin
                apb(1'h1, ADDR_T2_SEL, {24'hffffff, codes[j]});
                apb(1'h1, ADDR_NL1_SEL, {16'hffff, codes[j], 8'hff});
                apb(1'h1, ADDR_NL2_SEL, {24'hffffff, codes[j]});
                tick(8);
                e = (codes[j] == 8'h00) ? 1'h0 : (codes[j] == 8'h02) ? p[0] : ~p[0];
                check("routed", {29'h0, {3{e}}}, {29'h0, t2_clk, nl1_in, nl2_in});
                rd_chk(ADDR_T2_SEL, {24'h0, codes[j]});
                rd_chk(ADDR_NL1_SEL, {16'h0, codes[j], 8'h0});
                rd_chk(ADDR_NL2_SEL, {24'h0, codes[j]});
            end
        end
    endtask
    task automatic t_hv();
        apb(1'h1, ADDR_DIRECTION, 32'h00000000);
        hv <= 1'h1;
        tick(10);
        check("hv_pads", 32'h0, {pad_oe, pull_up});
        check("hv_in", 32'h0, {pull_dn, in_en});
        rd_chk(ADDR_STATUS, 32'h1);
        hv <= 1'h0;
        tick(10);
        check("hv_off", 32'h0000ffff, {16'h0, pad_oe});
    endtask

    initial begin
        ref_clk = 1'h0;
        rst_n = 1'h0;
        {psel, penable, pwrite, hv} = 4'h0;
        cmp = 1'h1;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_en = 16'h0000;
        ext_lvl = 16'h0000;
        func_req = '0;
        rp_src = '1;
        err_total = 0;
        samples_checked = 0;
        tick(4);
        rst_n <= 1'h1;
        tick(10);
        t_reset();
        t_analog();
        t_drive();
        t_priority();
        t_pulls();
        t_select();
        t_hv();
        end_sim();
    end
endmodule // io_pin_routing_tb
